// [hw/mmm_pkg.sv]
/*
  Package of the mixed unsigned-by-signed multiply-accumulate-and-move datapath:
  register offsets, field positions, reset values, opcodes and carrier types.
  Assumes a 32-bit APB register bus and a 16-word dual-port data memory.
*/
package mmm_pkg;

  localparam int unsigned MMM_ACC_W = 40;
  localparam int unsigned MMM_MEM_AW = 4;

  // register byte offsets
  localparam logic [11:0] MMM_OFF_CTRL = 12'h000;
  localparam logic [11:0] MMM_OFF_INSTR = 12'h004;
  localparam logic [11:0] MMM_OFF_OPREG = 12'h008;
  localparam logic [11:0] MMM_OFF_INDEX = 12'h00C;
  localparam logic [11:0] MMM_OFF_ACC_LO = 12'h010;
  localparam logic [11:0] MMM_OFF_ACC_HI = 12'h014;
  localparam logic [11:0] MMM_OFF_FLAGS = 12'h018;
  localparam logic [11:0] MMM_OFF_IRQ_STAT = 12'h01C;
  localparam logic [11:0] MMM_OFF_IRQ_MASK = 12'h020;
  localparam logic [11:0] MMM_OFF_MEM_ADDR = 12'h024;
  localparam logic [11:0] MMM_OFF_MEM_DATA = 12'h028;

  // instruction word fields, first byte in the top lane
  localparam int unsigned MMM_POS_BYTE0 = 24;
  localparam int unsigned MMM_POS_BYTE2 = 8;
  localparam int unsigned MMM_POS_QQQ = 0;
  localparam logic [7:0] MMM_BYTE0 = 8'h93;
  localparam logic [7:0] MMM_OPC_PLAIN = 8'h98;
  localparam logic [7:0] MMM_OPC_ROUND = 8'h99;
  localparam logic [7:0] MMM_OPC_SUB = 8'hA8;

  // index pointer update codes
  localparam logic [2:0] MMM_IDX_KEEP = 3'h0;
  localparam logic [2:0] MMM_IDX_INC = 3'h1;
  localparam logic [2:0] MMM_IDX_DEC = 3'h2;

  localparam logic [39:0] MMM_ROUND_CONST = 40'h00_0000_8000;
  localparam logic [39:0] MMM_SAT_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] MMM_SAT_NEG = 40'hFF_8000_0000;

  // irq bit positions
  localparam int unsigned MMM_IRQ_DONE = 0;
  localparam int unsigned MMM_IRQ_OVF = 1;
  localparam int unsigned MMM_IRQ_SAT = 2;
  localparam int unsigned MMM_IRQ_BAD = 3;
  localparam int unsigned MMM_IRQ_W = 4;

  localparam logic [39:0] MMM_RST_ACC = 40'h00_0000_0000;
  localparam logic MMM_RST_SAT_EN = 1'b0;

  typedef enum logic [1:0] {
    MMM_OP_PLAIN = 2'b00,
    MMM_OP_ROUND = 2'b01,
    MMM_OP_SUB = 2'b10,
    MMM_OP_NONE = 2'b11
  } mmm_op_t;

  // flag word layout, bit 0 is negative
  typedef struct packed {
    logic overflow_flag;
    logic saturated_flag;
    logic extension_used_flag;
    logic sticky_overflow_flag;
    logic carry_flag;
    logic zero_flag;
    logic negative_flag;
  } mmm_flags_t;

  localparam mmm_flags_t MMM_RST_FLAGS = 7'h00;

endpackage

// [hw/mmm_mac_move.sv]
/*
  Mixed unsigned-by-signed multiply-accumulate-and-move datapath with APB
  registers, its own 16-word dual-port data memory and one interrupt line.
  Assumes pclk is the core clock and that software writes one instruction
  word per operation into the instruction register.
*/
// Functional notes
// RULE1: first operand unsigned 16 bits, second signed 16 bits, multiplied.
// RULE2: signed 32-bit product sign-extended to 40 bits before accumulating.
// RULE3: plain variant adds extended product into the 40-bit accumulator.
// RULE4: rounding variant rounds the accumulator-plus-product sum before writeback.
// RULE5: rounding adds constant 00_0000_8000 to the 40-bit sum.
// RULE6: subtracting variant subtracts extended product from accumulator.
// RULE7: word at index pointer copied to second memory location alongside arithmetic.
// RULE8: copy destination follows the index pointer update code.
// RULE9: copy happens in the same instruction, no extra software sequence.
// RULE10: overflow flag set when result exceeds 40 bits, else cleared.
// RULE11: saturated flag set when accumulator saturated, else unchanged.
// RULE12: extension flag set when result uses extension bits, else cleared.
// RULE13: sticky overflow flag set on overflow, else kept.
// RULE14: carry flag set on carry (borrow for subtract), else cleared.
// RULE15: zero flag set when result equals zero, else cleared.
// RULE16: negative flag copies result most significant bit.
// RULE17: third instruction byte 99 decodes the rounding variant.
// RULE18: third instruction byte 98 decodes the plain accumulate variant.
// RULE19: with saturation enabled, overflow clamps to signed 32-bit extreme.
`timescale 1ns/1ps
`default_nettype none

module mmm_mac_move
  import mmm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  logic [15:0] dual_port_memory [2**MMM_MEM_AW];
  logic [MMM_ACC_W-1:0] accumulator_40b;
  logic [15:0] indirect_word_register;
  logic [MMM_MEM_AW-1:0] index_pointer;
  logic [MMM_MEM_AW-1:0] mem_addr;
  logic sat_en;
  mmm_flags_t flags;
  logic [MMM_IRQ_W-1:0] irq_stat;
  logic [MMM_IRQ_W-1:0] irq_mask;

  logic acc_phase;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic exec;
  mmm_op_t op;
  logic [2:0] idx_code;
  logic [MMM_MEM_AW-1:0] next_index;
  logic [15:0] op1;
  logic signed [32:0] prod_wide;
  logic [31:0] product;
  logic [39:0] ext_prod;
  logic [39:0] addend;
  logic [40:0] sum_u;
  logic [40:0] sum_s;
  logic [39:0] raw_res;
  logic ovf;
  logic ext_used;
  logic do_sat;
  logic [39:0] final_res;
  logic [MMM_IRQ_W-1:0] irq_events;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // one wait state: pready rises in the second access cycle
  assign acc_phase = psel && penable && !pready;
  // writes commit on the completing edge; reads load prdata one edge before it
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = acc_phase && !pwrite;

  always_comb
  begin
    unique case (paddr)
      MMM_OFF_CTRL, MMM_OFF_INSTR, MMM_OFF_OPREG, MMM_OFF_INDEX,
      MMM_OFF_ACC_LO, MMM_OFF_ACC_HI, MMM_OFF_FLAGS, MMM_OFF_IRQ_STAT,
      MMM_OFF_IRQ_MASK, MMM_OFF_MEM_ADDR, MMM_OFF_MEM_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign exec = wr_en && (paddr == MMM_OFF_INSTR) && (&pstrb);

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode

  always_comb
  begin
    op = MMM_OP_NONE;
    if (pwdata[MMM_POS_BYTE0 +: 8] == MMM_BYTE0)
    begin
      unique case (pwdata[MMM_POS_BYTE2 +: 8])
        MMM_OPC_ROUND: op = MMM_OP_ROUND; // see RULE17
        MMM_OPC_PLAIN: op = MMM_OP_PLAIN; // see RULE18
        MMM_OPC_SUB: op = MMM_OP_SUB;
        default: op = MMM_OP_NONE;
      endcase
    end
  end

  assign idx_code = pwdata[MMM_POS_QQQ +: 3];

  // destination of the copy is the pointer after its update
  always_comb
  begin
    unique case (idx_code)
      MMM_IDX_INC: next_index = index_pointer + 4'h1; // see RULE8
      MMM_IDX_DEC: next_index = index_pointer - 4'h1; // see RULE8
      default: next_index = index_pointer;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic

  assign op1 = dual_port_memory[index_pointer];
  // zero-extend op1 into a signed operand so the product is mixed-sign
  assign prod_wide = $signed({1'b0, op1}) * $signed(indirect_word_register); // see RULE1
  assign product = prod_wide[31:0];
  assign ext_prod = {{8{product[31]}}, product}; // see RULE2

  always_comb
  begin
    addend = (op == MMM_OP_SUB) ? ~ext_prod : ext_prod; // see RULE6
    sum_u = {1'b0, accumulator_40b} + {1'b0, addend}; // see RULE3
    sum_s = {accumulator_40b[39], accumulator_40b} + {addend[39], addend};
    if (op == MMM_OP_SUB)
    begin
      sum_u = sum_u + 41'h000_0000_0001;
      sum_s = sum_s + 41'h000_0000_0001;
    end
    if (op == MMM_OP_ROUND)
    begin
      sum_u = sum_u + {1'b0, MMM_ROUND_CONST}; // see RULE4, RULE5
      sum_s = sum_s + {MMM_ROUND_CONST[39], MMM_ROUND_CONST}; // see RULE5
    end
  end

  // carry from the unsigned adder, overflow and true sign from the signed one
  assign raw_res = sum_s[39:0];
  assign ovf = sum_s[40] ^ sum_s[39]; // see RULE10
  assign ext_used = !((&raw_res[39:31]) || !(|raw_res[39:31])); // see RULE12
  // clamp on any value outside the 32-bit range, true sign from bit 40
  assign do_sat = sat_en && (ovf || ext_used); // see RULE19
  assign final_res = do_sat ? (sum_s[40] ? MMM_SAT_NEG : MMM_SAT_POS) : raw_res; // see RULE19

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and flags

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      accumulator_40b <= MMM_RST_ACC;
    else if (ce)
    begin
      if (exec && op != MMM_OP_NONE)
        accumulator_40b <= final_res; // see RULE3, RULE4, RULE6
      else if (wr_en && paddr == MMM_OFF_ACC_LO)
        accumulator_40b[31:0] <= pwdata;
      else if (wr_en && paddr == MMM_OFF_ACC_HI)
        accumulator_40b[39:32] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= MMM_RST_FLAGS;
    else if (ce && exec && op != MMM_OP_NONE)
    begin
      flags.overflow_flag <= ovf; // see RULE10
      if (do_sat)
        flags.saturated_flag <= 1'b1; // see RULE11
      flags.extension_used_flag <= ext_used; // see RULE12
      if (ovf)
        flags.sticky_overflow_flag <= 1'b1; // see RULE13
      // subtract reports a borrow, the inverse of the adder carry
      flags.carry_flag <= (op == MMM_OP_SUB) ? !sum_u[40] : sum_u[40]; // see RULE14
      flags.zero_flag <= (final_res == 40'h00_0000_0000); // see RULE15
      flags.negative_flag <= final_res[39]; // see RULE16
    end
    else if (ce && wr_en && paddr == MMM_OFF_FLAGS)
    begin
      // software may only clear the two sticky flags
      if (pwdata[5])
        flags.saturated_flag <= 1'b0;
      if (pwdata[3])
        flags.sticky_overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer, operand register, control

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      index_pointer <= '0;
    else if (ce)
    begin
      if (exec && op != MMM_OP_NONE)
        index_pointer <= next_index;
      else if (wr_en && paddr == MMM_OFF_INDEX)
        index_pointer <= pwdata[MMM_MEM_AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      indirect_word_register <= 16'h0000;
    else if (ce && wr_en && paddr == MMM_OFF_OPREG)
      indirect_word_register <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sat_en <= MMM_RST_SAT_EN;
    else if (ce && wr_en && paddr == MMM_OFF_CTRL)
      sat_en <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_addr <= '0;
    else if (ce && wr_en && paddr == MMM_OFF_MEM_ADDR)
      mem_addr <= pwdata[MMM_MEM_AW-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= '0;
    else if (ce && wr_en && paddr == MMM_OFF_IRQ_MASK)
      irq_mask <= pwdata[MMM_IRQ_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory; the move uses the single write port, ahead of software writes

  // no reset: software loads the words before the first instruction
  always_ff @(posedge pclk)
  begin
    if (ce)
    begin
      // op1 is read before this edge, so a keep code rewrites the same word
      if (exec && op != MMM_OP_NONE)
        dual_port_memory[next_index] <= op1; // see RULE7, RULE9
      else if (wr_en && paddr == MMM_OFF_MEM_DATA)
        dual_port_memory[mem_addr] <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  always_comb
  begin
    irq_events = '0;
    irq_events[MMM_IRQ_DONE] = exec && (op != MMM_OP_NONE);
    irq_events[MMM_IRQ_OVF] = exec && (op != MMM_OP_NONE) && ovf;
    irq_events[MMM_IRQ_SAT] = exec && (op != MMM_OP_NONE) && do_sat;
    irq_events[MMM_IRQ_BAD] = exec && (op == MMM_OP_NONE);
  end

  // set wins over a simultaneous write-one-to-clear
  for (genvar g = 0; g < MMM_IRQ_W; g++)
  begin : g_irq_stat
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        irq_stat[g] <= 1'b0;
      else if (ce)
      begin
        if (irq_events[g])
          irq_stat[g] <= 1'b1;
        else if (wr_en && paddr == MMM_OFF_IRQ_STAT && pwdata[g])
          irq_stat[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_stat & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and handshake

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      MMM_OFF_CTRL: next_rdata[0] = sat_en;
      MMM_OFF_OPREG: next_rdata[15:0] = indirect_word_register;
      MMM_OFF_INDEX: next_rdata[MMM_MEM_AW-1:0] = index_pointer;
      MMM_OFF_ACC_LO: next_rdata = accumulator_40b[31:0];
      MMM_OFF_ACC_HI: next_rdata[7:0] = accumulator_40b[39:32];
      MMM_OFF_FLAGS: next_rdata[6:0] = flags;
      MMM_OFF_IRQ_STAT: next_rdata[MMM_IRQ_W-1:0] = irq_stat;
      MMM_OFF_IRQ_MASK: next_rdata[MMM_IRQ_W-1:0] = irq_mask;
      MMM_OFF_MEM_ADDR: next_rdata[MMM_MEM_AW-1:0] = mem_addr;
      MMM_OFF_MEM_DATA: next_rdata[15:0] = dual_port_memory[mem_addr];
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= acc_phase;
      pslverr <= acc_phase && !mapped;
    end
  end

  // read data holds between reads, so a slow master may take it late
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && rd_en)
      prdata <= next_rdata;
  end

endmodule

`default_nettype wire

// [tb/mmm_mac_move_monitor.sv]
/*
  Port-level checker for the multiply-accumulate-and-move block.
  Assumes ce is held high and the master keeps APB requests steady until pready.
*/
`timescale 1ns/1ps
`default_nettype none
module mmm_mac_move_monitor
  import mmm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_one_shot: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one cycle");
  chk_idle_quiet: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_unmapped: assert property (pready && paddr > MMM_OFF_MEM_DATA |-> pslverr)
    else $error("unmapped address accepted");
  chk_mapped_ok: assert property (pready && paddr <= MMM_OFF_MEM_DATA && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("mapped address refused");
  chk_err_read0: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_instr_read0: assert property (pready && !pwrite && paddr == MMM_OFF_INSTR
    |-> prdata == 32'h0)
    else $error("instruction register read not zero");
  chk_prdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("prdata changed outside a read");
  chk_irq_timing: assert property ($changed(irq) |-> $past(pready, 2))
    else $error("irq moved without a preceding transfer");
  cover property (pslverr);
  cover property (pready && pwrite && paddr == MMM_OFF_INSTR);
  cover property ($rose(irq));
endmodule
`default_nettype wire

// [tb/mmm_host_model.sv]
/*
  APB master standing in for the host core.
  Assumes pready is sampled at rising edges; idle address and data lines are scrambled on purpose.
*/
`timescale 1ns/1ps
`default_nettype none
module mmm_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // no stale address or data left for the slave to lean on
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/mixed_sign_mac_with_move_test.sv]
/*
  Self-checking bench for the multiply-accumulate-and-move block.
  Assumes the host model drives APB and a fixed seed makes the run repeatable.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, ex, ac); end end
module mixed_sign_mac_with_move_test
  import mmm_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, e, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb, ridx;
  logic [15:0] a, b;
  logic [1:0] k, m;
  logic [7:0] opc;
  logic [39:0] racc;
  mmm_flags_t rflags;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 41892;
  int cycles = 0;
  always #12.5 pclk = ~pclk;
  mmm_host_model h (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  mmm_mac_move DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    h.xfer(1'b1, ad, d, 4'hF, q, e);
  endtask
  task rd(input logic [11:0] ad);
    h.xfer(1'b0, ad, 32'h0, 4'hF, q, e);
  endtask
  function void exp_step(input logic [1:0] kk, input logic [15:0] x, input logic [15:0] y,
    input logic sat);
    logic signed [40:0] pe;
    logic [40:0] s, u, c;
    logic ov, ex;
    pe = $signed({1'b0, x}) * $signed(y);
    c = (kk == 2'd1) ? {1'b0, MMM_ROUND_CONST} : 41'h0;
    s = {racc[39], racc} + ((kk == 2'd2) ? -pe : pe) + c;
    u = {1'b0, racc} + ((kk == 2'd2) ? -{1'b0, pe[39:0]} : {1'b0, pe[39:0]}) + c;
    ov = s[40] ^ s[39];
    ex = !(&s[39:31]) && |s[39:31];
    // clamp is to 32 bits, so extension use alone also saturates
    racc = (sat && (ov || ex)) ? (s[40] ? MMM_SAT_NEG : MMM_SAT_POS) : s[39:0];
    rflags.overflow_flag = ov;
    rflags.saturated_flag = rflags.saturated_flag | (sat && (ov || ex));
    rflags.extension_used_flag = ex;
    rflags.sticky_overflow_flag = rflags.sticky_overflow_flag | ov;
    rflags.carry_flag = u[40];
    rflags.zero_flag = (racc == 40'h0);
    rflags.negative_flag = racc[39];
  endfunction
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    racc = MMM_RST_ACC;
    rflags = MMM_RST_FLAGS;
    ridx = 4'h0;
    rd(MMM_OFF_FLAGS);
    `CHK("flags_rst", 32'h0, q)
    rd(MMM_OFF_ACC_LO);
    `CHK("acc_rst", 32'h0, q)
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      a = $random(seed);
      b = $random(seed);
      k = {$random(seed)} % 3;
      m = {$random(seed)} % 3;
      se = $random(seed);
      if (i == 0)
      begin
        a = 16'h0;
        k = 2'd0;
      end
      if (i == 1)
      begin
        a = 16'hFFFF;
        b = 16'h8000;
      end
      if (i == 20)
      begin
        wr(MMM_OFF_FLAGS, 32'h28);
        rflags.saturated_flag = 1'b0;
        rflags.sticky_overflow_flag = 1'b0;
      end
      if (i == 30)
      begin
        wr(MMM_OFF_ACC_LO, 32'hFFFF_FFFF);
        wr(MMM_OFF_ACC_HI, 32'h0000_007F);
        racc = 40'h7F_FFFF_FFFF;
        a = 16'hFFFF;
        b = 16'h7FFF;
        k = 2'd0;
      end
      opc = (k == 2'd0) ? MMM_OPC_PLAIN : (k == 2'd1) ? MMM_OPC_ROUND : MMM_OPC_SUB;
      wr(MMM_OFF_MEM_ADDR, {28'h0, ridx});
      wr(MMM_OFF_MEM_DATA, {16'h0, a});
      wr(MMM_OFF_OPREG, {16'h0, b});
      wr(MMM_OFF_CTRL, {31'h0, se});
      wr(MMM_OFF_INSTR, {MMM_BYTE0, 8'h00, opc, 6'h00, m});
      exp_step(k, a, b, se);
      ridx = (m == 2'd1) ? ridx + 4'h1 : (m == 2'd2) ? ridx - 4'h1 : ridx;
      rd(MMM_OFF_ACC_LO);
      `CHK("acc_lo", racc[31:0], q)
      rd(MMM_OFF_ACC_HI);
      `CHK("acc_hi", {24'h0, racc[39:32]}, q)
      rd(MMM_OFF_FLAGS);
      `CHK("flags", {25'h0, rflags}, q)
      rd(MMM_OFF_INDEX);
      `CHK("index", {28'h0, ridx}, q)
      wr(MMM_OFF_MEM_ADDR, {28'h0, ridx});
      rd(MMM_OFF_MEM_DATA);
      `CHK("moved_word", {16'h0, a}, q)
    end
    $display("test random done");
    wr(MMM_OFF_IRQ_STAT, 32'hF);
    wr(MMM_OFF_IRQ_MASK, 32'h8);
    wr(MMM_OFF_INSTR, {MMM_BYTE0, 8'h00, 8'h55, 8'h00});
    rd(MMM_OFF_IRQ_STAT);
    `CHK("bad_opcode_stat", 32'h8, q)
    rd(MMM_OFF_ACC_LO);
    `CHK("bad_opcode_acc", racc[31:0], q)
    repeat (3) @(posedge pclk);
    `CHK("irq_set", 1'b1, irq)
    wr(MMM_OFF_IRQ_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("irq_masked", 1'b0, irq)
    wr(MMM_OFF_IRQ_MASK, 32'h8);
    wr(MMM_OFF_IRQ_STAT, 32'h8);
    repeat (3) @(posedge pclk);
    `CHK("irq_cleared", 1'b0, irq)
    // partial strobe must not execute, so no done bit appears
    h.xfer(1'b1, MMM_OFF_INSTR, {MMM_BYTE0, 8'h00, MMM_OPC_PLAIN, 8'h00}, 4'h7, q, e);
    rd(MMM_OFF_IRQ_STAT);
    `CHK("partial_strobe", 32'h0, q)
    rd(12'h0FC);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, q)
    rd(MMM_OFF_INSTR);
    `CHK("instr_read", 32'h0, q)
    $display("test irq and refusal done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(MMM_OFF_ACC_LO);
    `CHK("acc_rst2", 32'h0, q)
    rd(MMM_OFF_FLAGS);
    `CHK("flags_rst2", 32'h0, q)
    rd(MMM_OFF_INDEX);
    `CHK("index_rst2", 32'h0, q)
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
bind mmm_mac_move mmm_mac_move_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire
